// file: four_channel_ddc_bank.sv
// Four channel digital down-converter bank with APB register access
`timescale 1ns/1ns
`include "ddc_params.svh"

module four_channel_ddc_bank
  import ddc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_STAGES = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] adc_a,
  input wire logic signed [15:0] adc_b,
  input wire logic adc_valid,
  output logic rate_5g,
  output logic signed [NUM_CH-1:0][15:0] out_i,
  output logic signed [NUM_CH-1:0][15:0] out_q,
  output logic [NUM_CH-1:0] out_valid
);

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************

  // Quarter-wave cosine, 64 points per turn, index 16 is zero
  function automatic logic signed [15:0] qwave(input logic [4:0] k);
    case (k)
      5'd0: qwave = 16'sh3FFF;
      5'd1: qwave = 16'sh3FB1;
      5'd2: qwave = 16'sh3EC5;
      5'd3: qwave = 16'sh3D3F;
      5'd4: qwave = 16'sh3B21;
      5'd5: qwave = 16'sh3871;
      5'd6: qwave = 16'sh3537;
      5'd7: qwave = 16'sh3179;
      5'd8: qwave = 16'sh2D41;
      5'd9: qwave = 16'sh289A;
      5'd10: qwave = 16'sh238E;
      5'd11: qwave = 16'sh1E2B;
      5'd12: qwave = 16'sh187E;
      5'd13: qwave = 16'sh1294;
      5'd14: qwave = 16'sh0C7C;
      5'd15: qwave = 16'sh0646;
      default: qwave = 16'sh0000;
    endcase
  endfunction

  function automatic logic signed [15:0] cosine(input logic [5:0] p);
    logic [4:0] k;
    logic [4:0] kr;
    k = {1'b0, p[3:0]};
    kr = 5'd16 - k;
    case (p[5:4])
      2'd0: cosine = qwave(k);
      2'd1: cosine = -qwave(kr);
      2'd2: cosine = -qwave(k);
      default: cosine = qwave(kr);
    endcase
  endfunction

  function automatic logic signed [15:0] mul(input logic signed [15:0] a,
                                             input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b);
    mul = 16'(p >>> `MIX_SHIFT);
  endfunction

  // Seven-tap half-band, taps -1 0 9 16 9 0 -1 over 32; zero taps skipped.
  // The short kernel keeps 32 stages per rail affordable at the cost of
  // stopband depth.
  function automatic logic signed [15:0] halfband(input logic signed [15:0] a,
                                                  input logic signed [15:0] b,
                                                  input logic signed [15:0] c,
                                                  input logic signed [15:0] d,
                                                  input logic signed [15:0] e);
    logic signed [21:0] acc;
    acc = 22'(9) * (22'(b) + 22'(d)) + 22'(16) * 22'(c) - 22'(a) - 22'(e);
    halfband = 16'(acc >>> `HB_SHIFT);
  endfunction

  // ****************************************************************
  // APB register file
  // ****************************************************************

  logic [31:0] global_q;
  logic [31:0] freq_q [NUM_CH];
  logic [31:0] phase_q [NUM_CH];
  logic [31:0] ctrl_q [NUM_CH];
  logic [31:0] coef_q [NUM_CH];
  logic [NUM_CH-1:0] clamped;
  logic [NUM_CH-1:0] gf_active;
  logic [5:0] eff_order [NUM_CH];

  wire setup = psel && !penable;
  wire access_wr = psel && penable && pready && pwrite;
  wire is_global = paddr == `ADDR_GLOBAL;
  wire is_status = paddr == `ADDR_STATUS;
  wire [11:0] ch_ofs = paddr - `ADDR_CH_BASE;
  wire [7:0] ch_idx = 8'(ch_ofs >> `CH_STRIDE_LOG2);
  wire [3:0] reg_ofs = ch_ofs[3:0];
  wire is_chan = paddr >= `ADDR_CH_BASE && ch_idx < 8'(NUM_CH) && paddr[1:0] == 2'b00;
  wire [1:0] ch_sel = ch_idx[1:0];
  wire mapped = is_global || is_status || is_chan;
  wire [31:0] ch_rdata = reg_ofs == `OFS_FREQ ? freq_q[ch_sel] :
                         reg_ofs == `OFS_PHASE ? phase_q[ch_sel] :
                         reg_ofs == `OFS_CTRL ? ctrl_q[ch_sel] : coef_q[ch_sel];
  wire [31:0] rdata_d = is_global ? global_q :
                        is_status ? {24'h000000, gf_active, clamped} :
                        is_chan ? ch_rdata : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rdata_d : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      global_q <= `GLOBAL_RESET;
      rate_5g <= 1'b1;
    end else begin
      if (access_wr && is_global) begin
        global_q <= {31'h00000000, pwdata[`GLOBAL_RATE5G_BIT]};
      end
      rate_5g <= global_q[`GLOBAL_RATE5G_BIT];
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [5:0] MIN_ORD = (c < `NUM_FULL_CH) ? `MIN_ORDER_FULL : `MIN_ORDER_REDUCED;
    localparam bit FULL = c < `NUM_FULL_CH;

    // Only this channel's registers are written at its address
    wire wr_here = access_wr && is_chan && ch_sel == 2'(c);

    always_ff @(posedge clk) begin
      if (rst) begin
        freq_q[c] <= 32'h00000000;
        phase_q[c] <= 32'h00000000;
        ctrl_q[c] <= 32'h00000000;
        coef_q[c] <= `COEF_RESET;
      end else if (wr_here) begin
        if (reg_ofs == `OFS_FREQ) freq_q[c] <= pwdata;
        if (reg_ofs == `OFS_PHASE) phase_q[c] <= pwdata;
        if (reg_ofs == `OFS_CTRL) ctrl_q[c] <= pwdata & `CTRL_MASK;
        if (reg_ofs == `OFS_COEF) coef_q[c] <= pwdata;
      end
    end

    wire bypass_t byp = bypass_t'(ctrl_q[c][`CTRL_BYP_LSB +: 2]);
    wire cplx = ctrl_q[c][`CTRL_CPLX_BIT];
    wire source_t src = source_t'(ctrl_q[c][`CTRL_SRC_LSB +: 2]);
    wire [5:0] order = ctrl_q[c][`CTRL_ORD_LSB +: 6];
    wire raw = FULL && byp == BYP_RAW;
    wire [5:0] ord_lim = order > 6'(NUM_STAGES) ? 6'(NUM_STAGES) : order;
    // Rate floors keep each rail at or under its output limit
    assign clamped[c] = !raw && ord_lim < MIN_ORD;
    assign eff_order[c] = raw ? 6'h00 : (clamped[c] ? MIN_ORD : ord_lim);
    assign gf_active[c] = ctrl_q[c][`CTRL_GFEN_BIT] && eff_order[c] >= `GF_MIN_ORDER;

    // Crosspoint and differential former
    wire signed [15:0] diff = 16'(adc_a - adc_b);
    wire signed [15:0] real_in = src == SRC_A ? adc_a :
                                 src == SRC_B ? adc_b : diff;

    // Oscillator: accumulator advances once per converter sample
    logic [31:0] acc_q;
    always_ff @(posedge clk) begin
      if (rst) acc_q <= 32'h00000000;
      else if (adc_valid) acc_q <= acc_q + freq_q[c];
    end
    wire [5:0] ang = 6'((acc_q + phase_q[c]) >> 26);
    wire signed [15:0] lo_c = cosine(ang);
    wire signed [15:0] lo_s = cosine(6'(ang - 6'd16));

    // Mixer: (x)(cos - j sin) for real, (i + jq)(cos - j sin) for complex
    wire signed [15:0] mix_i = cplx ? 16'(mul(adc_a, lo_c) + mul(adc_b, lo_s)) :
                               mul(real_in, lo_c);
    wire signed [15:0] mix_q = cplx ? 16'(mul(adc_b, lo_c) - mul(adc_a, lo_s)) :
                               16'(-mul(real_in, lo_s));
    wire signed [15:0] pre_i = byp == BYP_MIX ? mix_i : (cplx ? adc_a : real_in);
    wire signed [15:0] pre_q = byp == BYP_MIX ? mix_q : (cplx ? adc_b : 16'sh0000);

    // Decimation cascade; element 0 is the chain input
    logic signed [15:0] si [NUM_STAGES+1];
    logic signed [15:0] sq [NUM_STAGES+1];
    logic sv [NUM_STAGES+1];
    assign si[0] = pre_i;
    assign sq[0] = pre_q;
    assign sv[0] = adc_valid;

    for (genvar s = 0; s < NUM_STAGES; s++) begin : g_hb
      logic signed [15:0] ti_q [6];
      logic signed [15:0] tq_q [6];
      logic keep_q;
      logic signed [15:0] oi_q;
      logic signed [15:0] oq_q;
      logic ov_q;
      wire on = 6'(s) < eff_order[c];
      // Filtered value is formed over the full-rate taps before any skip
      wire signed [15:0] fi = halfband(si[s], ti_q[1], ti_q[2], ti_q[3], ti_q[5]);
      wire signed [15:0] fq = halfband(sq[s], tq_q[1], tq_q[2], tq_q[3], tq_q[5]);
      always_ff @(posedge clk) begin
        if (rst || !on) begin
          for (int t = 0; t < 6; t++) begin
            ti_q[t] <= 16'sh0000;
            tq_q[t] <= 16'sh0000;
          end
          keep_q <= 1'b0;
        end else if (sv[s]) begin
          ti_q[0] <= si[s];
          tq_q[0] <= sq[s];
          for (int t = 1; t < 6; t++) begin
            ti_q[t] <= ti_q[t-1];
            tq_q[t] <= tq_q[t-1];
          end
          keep_q <= !keep_q;
        end
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          oi_q <= 16'sh0000;
          oq_q <= 16'sh0000;
          ov_q <= 1'b0;
        end else begin
          oi_q <= on ? fi : si[s];
          oq_q <= on ? fq : sq[s];
          ov_q <= on ? (sv[s] && keep_q) : sv[s];
        end
      end
      assign si[s+1] = oi_q;
      assign sq[s+1] = oq_q;
      assign sv[s+1] = ov_q;
    end

    // General filter: equalizer mode multiplies by c0 + j c1; split mode
    // runs c0 x[n] + c1 x[n-1] on each rail alone.
    wire signed [15:0] k0 = coef_q[c][15:0];
    wire signed [15:0] k1 = coef_q[c][31:16];
    wire signed [15:0] gi = si[NUM_STAGES];
    wire signed [15:0] gq = sq[NUM_STAGES];
    logic signed [15:0] pi_q;
    logic signed [15:0] pq_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        pi_q <= 16'sh0000;
        pq_q <= 16'sh0000;
      end else if (sv[NUM_STAGES]) begin
        pi_q <= gi;
        pq_q <= gq;
      end
    end
    wire eq = ctrl_q[c][`CTRL_GFEQ_BIT];
    wire signed [15:0] gf_i = eq ? 16'(mul(gi, k0) - mul(gq, k1)) :
                              16'(mul(gi, k0) + mul(pi_q, k1));
    wire signed [15:0] gf_q = eq ? 16'(mul(gi, k1) + mul(gq, k0)) :
                              16'(mul(gq, k0) + mul(pq_q, k1));

    // Raw mode bypasses everything on the full channels
    always_ff @(posedge clk) begin
      if (rst) begin
        out_i[c] <= 16'sh0000;
        out_q[c] <= 16'sh0000;
        out_valid[c] <= 1'b0;
      end else if (raw) begin
        // Data hold between samples so idle converter lines never leak out
        if (adc_valid) begin
          out_i[c] <= adc_a;
          out_q[c] <= adc_b;
        end
        out_valid[c] <= adc_valid;
      end else begin
        if (sv[NUM_STAGES]) begin
          out_i[c] <= gf_active[c] ? gf_i : gi;
          out_q[c] <= gf_active[c] ? gf_q : gq;
        end
        out_valid[c] <= sv[NUM_STAGES];
      end
    end
  end

endmodule

// file: ddc_params.svh
// Constants for the four channel down-converter bank
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

`define ADDR_GLOBAL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CH_BASE 12'h010
`define CH_STRIDE_LOG2 4
`define OFS_FREQ 4'h0
`define OFS_PHASE 4'h4
`define OFS_CTRL 4'h8
`define OFS_COEF 4'hC

`define CTRL_BYP_LSB 0
`define CTRL_CPLX_BIT 2
`define CTRL_SRC_LSB 3
`define CTRL_ORD_LSB 5
`define CTRL_GFEN_BIT 11
`define CTRL_GFEQ_BIT 12
`define CTRL_MASK 32'h00001FFF

`define GLOBAL_RATE5G_BIT 0
`define GLOBAL_RESET 32'h00000001
`define COEF_RESET 32'h00004000

`define MIN_ORDER_FULL 6'h01
`define MIN_ORDER_REDUCED 6'h03
`define GF_MIN_ORDER 6'h03
`define NUM_FULL_CH 2
`define MIX_SHIFT 14
`define HB_SHIFT 5

`endif

// file: ddc_pkg.sv
// Types shared by the down-converter bank
package ddc_pkg;
  typedef enum logic [1:0] {BYP_MIX, BYP_MIXER_OFF, BYP_RAW, BYP_RSVD} bypass_t;
  typedef enum logic [1:0] {SRC_A, SRC_B, SRC_DIFF, SRC_DIFF2} source_t;
  typedef logic signed [15:0] sample_t;
endpackage

// file: four_channel_ddc_bank_asserts.sv
// Port checks for the down-converter bank
`timescale 1ns/1ns
module four_channel_ddc_bank_asserts #(
  parameter int NUM_STAGES = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_valid,
  input wire logic rate_5g,
  input wire logic [3:0] out_valid
);
  wire wr_glob = psel && penable && pwrite && pready && paddr == 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_quiet2; (!out_valid[2]) [*7]; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("prdata outside access");
  property p_rst; $fell(rst) |-> !pready && out_valid == 4'h0 && rate_5g; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_rate; $changed(rate_5g) |-> $past(wr_glob) || $past(wr_glob, 2); endproperty
  a_rate: assert property (p_rate) else $error("rate mode moved alone");
  property p_gap; out_valid[2] |=> s_quiet2; endproperty
  a_gap: assert property (p_gap) else $error("reduced channel too fast");
  property p_lat; out_valid[2] |-> $past(adc_valid, NUM_STAGES + 1); endproperty
  a_lat: assert property (p_lat) else $error("output without sample");
endmodule

// file: adc_stream_model.sv
// Converter sample source in front of the bank
`timescale 1ns/1ns
module adc_stream_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic gap,
  input wire logic ramp,
  input wire logic signed [15:0] a_val,
  input wire logic signed [15:0] b_val,
  output logic signed [15:0] adc_a = 16'sh0,
  output logic signed [15:0] adc_b = 16'sh0,
  output logic adc_valid = 1'b0
);
  logic odd_q = 1'b0;
  logic signed [15:0] step_q = 16'sh0;
  wire take = run && (!gap || odd_q);
  // Lines are inverted between samples so nothing relies on stale data
  always @(posedge clk) begin
    odd_q <= ~odd_q;
    adc_valid <= take && !rst;
    if (take && !rst) begin
      step_q <= ramp ? step_q + 16'sh1 : 16'sh0;
      adc_a <= a_val + step_q;
      adc_b <= b_val - step_q;
    end else begin
      adc_a <= ~adc_a;
      adc_b <= ~adc_b;
    end
  end
endmodule

// file: four_channel_ddc_bank_tb.sv
// Self-checking bench for the down-converter bank
`timescale 1ns/1ns
`include "ddc_params.svh"
module four_channel_ddc_bank_tb import ddc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cnt_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rate_5g, adc_valid, er;
  logic run = 1'b0, gap = 1'b0, ramp = 1'b0;
  logic signed [15:0] a_val = 16'sh3E8, b_val = 16'sh12C, adc_a, adc_b;
  logic signed [3:0][15:0] out_i, out_q;
  logic [3:0] out_valid;
  int err_count = 0, cmp_count = 0, cyc = 0;
  int cnt [4];
  always #50 clk = ~clk;
  four_channel_ddc_bank #(.NUM_STAGES(4)) four_channel_ddc_bank_inst (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_a, .adc_b,
    .adc_valid, .rate_5g, .out_i, .out_q, .out_valid);
  adc_stream_model adc_stream_model_inst (.clk, .rst, .run, .gap, .ramp, .a_val, .b_val,
    .adc_a, .adc_b, .adc_valid);
  always @(posedge clk) begin
    cyc++;
    if (cnt_en) begin
      for (int c = 0; c < 4; c++) cnt[c] += out_valid[c];
    end
    if (cyc == 6000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic signed [31:0] ex, got, input int tol);
    logic signed [31:0] d;
    d = ex - got;
    cmp_count++;
    if ((^got) === 1'bx || d > tol || d < -tol) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", nm, ex, got);
    end
  endtask
  // Setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look mid-cycle: the value seen here is what the next rising edge samples
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      $display("Error pready expected 1 seen 0");
    end
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ca(int c, logic [3:0] o);
    return `ADDR_CH_BASE + 12'(c << `CH_STRIDE_LOG2) + 12'(o);
  endfunction
  function automatic logic [31:0] cw(bypass_t by, bit cx, source_t s, int o, bit gf);
    return 32'(by) | 32'(cx) << `CTRL_CPLX_BIT | 32'(s) << `CTRL_SRC_LSB
      | 32'(o) << `CTRL_ORD_LSB | 32'(gf) << `CTRL_GFEN_BIT | 32'(gf) << `CTRL_GFEQ_BIT;
  endfunction
  task automatic t_regs();
    apb(0, `ADDR_GLOBAL, 0);
    chk("global", 1, rd, 0);
    apb(1, `ADDR_GLOBAL, 0);
    repeat (2) @(posedge clk);
    chk("rate", 0, rate_5g, 0);
    apb(1, ca(1, `OFS_CTRL), 32'hFFFFFFFF);
    apb(0, ca(1, `OFS_CTRL), 0);
    chk("ctrl", `CTRL_MASK, rd, 0);
    apb(1, ca(0, `OFS_FREQ), 32'h12345678);
    apb(0, ca(1, `OFS_FREQ), 0);
    chk("freq1", 0, rd, 0);
    apb(0, ca(0, `OFS_FREQ), 0);
    chk("freq0", 32'h12345678, rd, 0);
    apb(0, ca(3, `OFS_COEF), 0);
    chk("coef", `COEF_RESET, rd, 0);
    apb(0, 12'h100, 0);
    chk("unmapped", 1, er, 0);
    apb(1, 12'h012, 32'h5);
    chk("unaligned", 1, er, 0);
    apb(1, `ADDR_GLOBAL, 1);
  endtask
  // Four channels at once; channel 0 is moved from order 1 to order 2 halfway through
  task automatic t_stream();
    apb(1, ca(0, `OFS_CTRL), cw(BYP_MIXER_OFF, 1, SRC_A, 1, 0));
    apb(1, ca(1, `OFS_PHASE), 32'h40000000);
    apb(1, ca(1, `OFS_CTRL), cw(BYP_MIX, 0, SRC_A, 2, 0));
    apb(1, ca(2, `OFS_CTRL), cw(BYP_MIXER_OFF, 0, SRC_B, 0, 0));
    apb(1, ca(3, `OFS_CTRL), cw(BYP_MIXER_OFF, 0, SRC_DIFF, 4, 1));
    cnt = '{default: 0};
    cnt_en = 1'b1;
    run <= 1'b1;
    repeat (125) @(posedge clk);
    apb(1, ca(0, `OFS_CTRL), cw(BYP_MIXER_OFF, 1, SRC_A, 2, 0));
    repeat (125) @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
    cnt_en = 1'b0;
    chk("cnt0", 96, cnt[0], 3);
    chk("cnt1", 64, cnt[1], 1);
    chk("cnt2", 32, cnt[2], 1);
    chk("cnt3", 16, cnt[3], 1);
    chk("i0", 1000, $signed(out_i[0]), 2);
    chk("q0", 300, $signed(out_q[0]), 2);
    chk("i1", 0, $signed(out_i[1]), 4);
    chk("q1", -1000, $signed(out_q[1]), 4);
    chk("i2", 300, $signed(out_i[2]), 2);
    chk("q2", 0, $signed(out_q[2]), 2);
    chk("i3", 700, $signed(out_i[3]), 2);
    chk("q3", 0, $signed(out_q[3]), 2);
    apb(0, `ADDR_STATUS, 0);
    chk("gf_on", 8, rd[7:4], 0);
  endtask
  task automatic t_raw();
    logic signed [15:0] pa;
    logic pv;
    apb(1, ca(0, `OFS_CTRL), cw(BYP_RAW, 1, SRC_A, 0, 0));
    gap <= 1'b1;
    ramp <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (24) begin
      #1;
      pa = adc_a;
      pv = adc_valid;
      @(posedge clk);
      #1;
      chk("raw_v", pv, out_valid[0], 0);
      if (pv) chk("raw_i", pa, $signed(out_i[0]), 0);
    end
    @(posedge clk);
    run <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_stream();
    t_raw();
    print_verdict();
  end
endmodule
bind four_channel_ddc_bank four_channel_ddc_bank_asserts #(.NUM_STAGES(NUM_STAGES)) chk_inst (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .adc_valid,
  .rate_5g, .out_valid);
